//--- logic/block_move_exec.sv
// Purpose: fetch and run block move instructions on a scsi-style bus
// Assumes: one clock, synchronous active high reset, inputs synchronous
// Notes: moves carry one byte per memory transfer, one byte per handshake; fetches read whole words
`timescale 1ns/1ns
`default_nettype none
module block_move_exec (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // memory master
    output bmove_pkg::mem_req_s        mem_req,
    input  wire logic                  mem_ack,
    input  wire logic [31:0]           mem_rdata,
    // scsi side
    input  wire logic                  scsi_req_in,
    input  wire logic                  scsi_ack_in,
    input  wire logic                  scsi_atn_in,
    input  wire logic                  scsi_parity_err,
    input  wire logic [2:0]            scsi_phase_in,
    input  wire logic [7:0]            scsi_data_in,
    output bmove_pkg::scsi_out_s       scsi_out,
    output logic                       irq
);
    typedef enum logic [3:0] {
        st_idle, st_fetch0, st_fetch1, st_indir, st_decode, st_wait_conn,
        st_wait_req, st_cdb, st_mem, st_scsi, st_scsi_end, st_halt
    } state_e;

    state_e      state_q, state_d;
    logic [31:0] cmd_q, cmd_d;        // opcode byte plus count
    logic [31:0] addr_q, addr_d;
    logic [31:0] pointer_save_register_q, pointer_save_register_d;
    logic [31:0] pc_q, pc_d;
    logic [7:0]  irq_en_q, irq_en_d;
    logic [5:0]  ctrl_q, ctrl_d;
    logic [2:0]  latched_phase_q, latched_phase_d;
    logic [3:0]  status_q, status_d;  // illegal, mismatch, halt, done
    logic [7:0]  byte_q, byte_d;
    logic        ack_q, ack_d, atn_q, atn_d, req_q, req_d, wack_q, wack_d;
    logic        mcyc_q, mcyc_d, mwe_q, mwe_d;
    logic [31:0] madr_q, madr_d, mdat_q, mdat_d, rdat_q, rdat_d;

    wire         wb_hit   = wb_cyc_i & wb_stb_i & ~wack_q;
    wire         target   = ctrl_q[bmove_pkg::ctrl_target_bit];
    wire  [1:0]  illegal_op_irq_enable      = cmd_q[bmove_pkg::opc_hi:bmove_pkg::opc_lo];
    wire  [2:0]  phase    = cmd_q[bmove_pkg::phase_hi:bmove_pkg::phase_lo];
    wire  [23:0] count    = cmd_q[23:0];
    wire         data_in  = target ? ~phase[0] : phase[0]; // byte flows into memory

    // cdb length from group code in top three bits
    function automatic logic [23:0] cdb_len(input logic [7:0] b, input logic [23:0] c);
        unique case (b[7:5])
            3'h0:      cdb_len = bmove_pkg::cdb_len6;
            3'h1, 3'h2: cdb_len = bmove_pkg::cdb_len10;
            3'h5:      cdb_len = bmove_pkg::cdb_len12;
            default:   cdb_len = c;
        endcase
    endfunction

    // next state of engine and registers
    always_comb begin
        state_d = state_q; cmd_d = cmd_q; addr_d = addr_q; pointer_save_register_d = pointer_save_register_q;
        pc_d = pc_q; irq_en_d = irq_en_q; ctrl_d = ctrl_q; latched_phase_d = latched_phase_q;
        status_d = status_q; byte_d = byte_q; ack_d = ack_q; atn_d = atn_q;
        req_d = req_q; wack_d = 1'b0; mcyc_d = mcyc_q; mwe_d = mwe_q;
        madr_d = madr_q; mdat_d = mdat_q; rdat_d = rdat_q;
        ctrl_d[bmove_pkg::ctrl_clr_ack]  = 1'b0;
        ctrl_d[bmove_pkg::ctrl_clr_stat] = 1'b0;
        // wishbone register access
        if (wb_hit) begin
            wack_d = 1'b1;
            rdat_d = bmove_pkg::reset_word;
            unique case (wb_adr_i)
                bmove_pkg::off_ctrl:   rdat_d = {26'h0, ctrl_q};
                bmove_pkg::off_status: rdat_d = {24'h0, (state_q == st_idle) ? 4'h0 : 4'h1, status_q};
                bmove_pkg::off_cmd:    rdat_d = cmd_q;
                bmove_pkg::off_addr:   rdat_d = addr_q;
                bmove_pkg::off_pointer_save_register:   rdat_d = pointer_save_register_q;
                bmove_pkg::off_irq_en: rdat_d = {24'h0, irq_en_q};
                bmove_pkg::off_phase:  rdat_d = {29'h0, latched_phase_q};
                default:               rdat_d = bmove_pkg::reset_word;
            endcase
            if (wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    bmove_pkg::off_ctrl:   ctrl_d = wb_dat_i[5:0];
                    bmove_pkg::off_addr:   pc_d = wb_dat_i;
                    bmove_pkg::off_irq_en: irq_en_d = wb_dat_i[7:0];
                    default: ;
                endcase
            end
        end
        if (ctrl_q[bmove_pkg::ctrl_clr_ack])
            ack_d = 1'b0;
        if (ctrl_q[bmove_pkg::ctrl_clr_stat])
            status_d = 4'h0;
        unique case (state_q)
            st_idle: if (ctrl_q[bmove_pkg::ctrl_start_bit] && status_q[2:0] == 3'h0) begin
                ctrl_d[bmove_pkg::ctrl_start_bit] = 1'b0;
                mcyc_d = 1'b1; mwe_d = 1'b0; madr_d = pc_q;
                state_d = st_fetch0;
            end
            st_fetch0: if (mem_ack) begin
                cmd_d = mem_rdata;
                madr_d = pc_q + 32'h4;
                state_d = st_fetch1;
            end
            st_fetch1: if (mem_ack) begin
                pc_d = pc_q + 32'h8;
                if (cmd_q[bmove_pkg::ind_bit]) begin
                    pointer_save_register_d = mem_rdata;
                    madr_d = mem_rdata;
                    state_d = st_indir;
                end else begin
                    addr_d = mem_rdata;
                    mcyc_d = 1'b0;
                    state_d = st_decode;
                end
            end
            st_indir: if (mem_ack) begin
                addr_d = mem_rdata;
                mcyc_d = 1'b0;
                state_d = st_decode;
            end
            st_decode: begin
                if ((target && illegal_op_irq_enable != 2'h0) || (!target && illegal_op_irq_enable != 2'h1)) begin
                    status_d[3] = 1'b1;
                    state_d = st_halt;
                end else
                    state_d = st_wait_conn;
            end
            st_wait_conn: if (ctrl_q[bmove_pkg::ctrl_connected]) begin
                if (target) begin
                    if (phase == bmove_pkg::ph_cmd) begin
                        req_d = 1'b1;
                        state_d = st_cdb;
                    end else if (count == 24'h0) begin
                        // empty move: done, go fetch the next instruction
                        status_d[0] = 1'b1;
                        mcyc_d = 1'b1; mwe_d = 1'b0; madr_d = pc_q;
                        state_d = st_fetch0;
                    end else
                        state_d = st_mem;
                end else
                    state_d = st_wait_req;
            end
            st_wait_req: if (scsi_req_in && !ack_q) begin
                latched_phase_d = scsi_phase_in;
                if (scsi_phase_in != phase) begin
                    status_d[2] = 1'b1;
                    state_d = st_halt;
                end else if (count == 24'h0) begin
                    status_d[0] = 1'b1;
                    mcyc_d = 1'b1; mwe_d = 1'b0; madr_d = pc_q;
                    state_d = st_fetch0;
                end else begin
                    if (phase == bmove_pkg::ph_msg_out)
                        atn_d = 1'b1;
                    state_d = st_mem;
                end
            end
            st_cdb: if (scsi_ack_in) begin
                req_d = 1'b0;
                if (cdb_len(scsi_data_in, count) == 24'h0) begin
                    status_d[3] = 1'b1;
                    state_d = st_halt;
                end else begin
                    cmd_d[23:0] = cdb_len(scsi_data_in, count);
                    byte_d = scsi_data_in;
                    mcyc_d = 1'b1; mwe_d = 1'b1;
                    madr_d = addr_q; mdat_d = {24'h0, scsi_data_in};
                    state_d = st_mem;
                end
            end
            st_mem: begin
                if (!mcyc_q) begin
                    mwe_d = data_in; madr_d = addr_q;
                    if (!data_in)
                        mcyc_d = 1'b1;
                    else if (target) begin
                        // byte must arrive before memory is written
                        req_d = 1'b1;
                        if (req_q && scsi_ack_in) begin
                            byte_d = scsi_data_in; mdat_d = {24'h0, scsi_data_in};
                            req_d = 1'b0;
                            mcyc_d = 1'b1;
                        end
                    end else if (scsi_req_in && !ack_q) begin
                        byte_d = scsi_data_in; mdat_d = {24'h0, scsi_data_in};
                        ack_d = 1'b1;
                        mcyc_d = 1'b1;
                    end
                end else if (mem_ack) begin
                    mcyc_d = 1'b0;
                    if (!data_in) byte_d = mem_rdata[7:0];
                    cmd_d[23:0] = count - 24'h1;
                    addr_d = addr_q + 32'h1;
                    // inbound bytes still owe the end of their handshake
                    state_d = data_in ? st_scsi_end : st_scsi;
                end
            end
            st_scsi: begin
                if (target) req_d = 1'b1;
                else if (scsi_req_in && !ack_q) begin
                    if (phase == bmove_pkg::ph_msg_out && count == 24'h0)
                        atn_d = 1'b0;
                    ack_d = 1'b1;
                end
                if ((target && scsi_ack_in) || (!target && ack_q))
                    state_d = st_scsi_end;
            end
            st_scsi_end: begin
                req_d = 1'b0;
                if (target && (scsi_atn_in || scsi_parity_err) && !ctrl_q[bmove_pkg::ctrl_dhpa_bit]) begin
                    status_d[1] = 1'b1;
                    state_d = st_halt;
                end else if (!target && !scsi_req_in) begin
                    if (!(phase == bmove_pkg::ph_msg_in && count == 24'h0))
                        ack_d = 1'b0;
                    state_d = st_mem;
                end else if (target && !scsi_ack_in)
                    state_d = st_mem;
                // count spent: fetch the next instruction
                if (state_d == st_mem && count == 24'h0) begin
                    status_d[0] = 1'b1;
                    mcyc_d = 1'b1; mwe_d = 1'b0; madr_d = pc_q;
                    state_d = st_fetch0;
                end
            end
            st_halt: begin
                mcyc_d = 1'b0; req_d = 1'b0;
                if (status_q[3:1] == 3'h0) state_d = st_idle;
            end
            default: state_d = st_idle;
        endcase
    end

    // registered state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= st_idle; cmd_q <= bmove_pkg::reset_word; addr_q <= bmove_pkg::reset_word;
            pointer_save_register_q <= bmove_pkg::reset_word; pc_q <= bmove_pkg::reset_word; irq_en_q <= 8'h00;
            ctrl_q <= 6'h00; latched_phase_q <= 3'h0; status_q <= 4'h0; byte_q <= 8'h00;
            ack_q <= 1'b0; atn_q <= 1'b0; req_q <= 1'b0; wack_q <= 1'b0;
            mcyc_q <= 1'b0; mwe_q <= 1'b0; madr_q <= bmove_pkg::reset_word;
            mdat_q <= bmove_pkg::reset_word; rdat_q <= bmove_pkg::reset_word;
        end else begin
            state_q <= state_d; cmd_q <= cmd_d; addr_q <= addr_d; pointer_save_register_q <= pointer_save_register_d;
            pc_q <= pc_d; irq_en_q <= irq_en_d; ctrl_q <= ctrl_d; latched_phase_q <= latched_phase_d;
            status_q <= status_d; byte_q <= byte_d; ack_q <= ack_d; atn_q <= atn_d;
            req_q <= req_d; wack_q <= wack_d; mcyc_q <= mcyc_d; mwe_q <= mwe_d;
            madr_q <= madr_d; mdat_q <= (mwe_d && !data_in) ? mdat_d : (data_in ? mdat_d : {24'h0, byte_d});
            rdat_q <= rdat_d;
        end
    end

    // outputs
    assign wb_ack_o = wack_q;
    assign wb_dat_o = rdat_q;
    assign mem_req  = '{cyc: mcyc_q, we: mwe_q, adr: madr_q, dat: mdat_q};
    assign scsi_out = '{ack: ack_q, atn: atn_q, req: req_q, phase: phase,
                        data: byte_q, phase_oe: target && state_q != st_idle && state_q != st_halt};
    assign irq = (status_q[3] && irq_en_q[bmove_pkg::illop_en_bit]) || status_q[2] || status_q[1];

    // a_illegal_irq: illegal flag with enable raises irq in the same cycle
    a_illegal_irq: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(status_q[3]) && irq_en_q[0] |-> irq) else $error("illegal op did not raise irq");
    a_mismatch_stop: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(status_q[2]) |-> state_q == st_halt && !mcyc_q ##1 !mem_req.cyc) else $error("fetch after mismatch");
    a_count_falls: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_mem && mcyc_q && mem_ack |=> count == $past(count) - 24'h1) else $error("count not decremented");
    a_addr_rises: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_mem && mcyc_q && mem_ack |=> addr_q == $past(addr_q) + 32'h1) else $error("address not incremented");
    a_fetch_two: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_fetch0 && mem_ack |=> state_q == st_fetch1 && madr_q == $past(madr_q) + 32'h4) else $error("second fetch wrong");
    a_direct_addr: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_fetch1 && mem_ack && !cmd_q[29] |=> addr_q == $past(mem_rdata)) else $error("direct address not loaded");
    a_indirect_read: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_fetch1 && mem_ack && cmd_q[29] |=> state_q == st_indir && madr_q == $past(mem_rdata)) else $error("no pointer read");
    a_target_opc: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_decode && target && illegal_op_irq_enable != 2'h0 |=> status_q[3]) else $error("target opcode not flagged");
    a_init_opc: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_decode && !target && illegal_op_irq_enable != 2'h1 |=> status_q[3]) else $error("initiator opcode not flagged");
    a_phase_latch: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_wait_req && scsi_req_in && !ack_q |=> latched_phase_q == $past(scsi_phase_in)) else $error("phase not latched");

    // end of a move and the fetch that follows it
    sequence s_move_done;
        state_q == st_scsi_end && state_d == st_fetch0;
    endsequence
    sequence s_next_fetch;
        mem_req.cyc && !mem_req.we && mem_req.adr == pc_q;
    endsequence
    a_next_fetch: assert property (@(posedge sys_clk) disable iff (rst)
        s_move_done |=> s_next_fetch) else $error("no fetch after move");
    a_msg_in_hold: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_scsi_end && !target && !scsi_req_in && phase == bmove_pkg::ph_msg_in
        && count == 24'h0 |=> scsi_out.ack) else $error("final message ack dropped");
    a_atn_before_ack: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ack_q) && !target && phase == bmove_pkg::ph_msg_out && count == 24'h0 |-> !atn_q)
        else $error("atn still up at last ack");
    a_target_halt: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_scsi_end && target && scsi_atn_in && !ctrl_q[bmove_pkg::ctrl_dhpa_bit]
        |=> state_q == st_halt && status_q[1]) else $error("no halt on atn");
    a_cdb_len: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_cdb && scsi_ack_in && scsi_data_in[7:5] == 3'h0
        |=> count == bmove_pkg::cdb_len6 && state_q == st_mem) else $error("group 0 length not set");
    a_conn_wait: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == st_wait_conn && !ctrl_q[bmove_pkg::ctrl_connected] |=> state_q == st_wait_conn)
        else $error("moved before connection");
endmodule // block_move_exec
`default_nettype wire

//--- logic/bmove_pkg.sv
// Purpose: shared constants and carriers for the block move executor
// Assumes: 32-bit classic wishbone slave, 20 MHz sys_clk
// Notes: register offsets are byte addresses of aligned words
package bmove_pkg;
    // register byte offsets
    localparam logic [7:0] off_ctrl     = 8'h00;
    localparam logic [7:0] off_status   = 8'h04;
    localparam logic [7:0] off_cmd      = 8'h08;
    localparam logic [7:0] off_addr     = 8'h0c;
    localparam logic [7:0] off_pointer_save_register     = 8'h10;
    localparam logic [7:0] off_irq_en   = 8'h14;
    localparam logic [7:0] off_phase    = 8'h18;
    // control register fields
    localparam int ctrl_start_bit  = 0;
    localparam int ctrl_target_bit = 1;
    localparam int ctrl_dhpa_bit   = 2;
    localparam int ctrl_clr_ack    = 3;
    localparam int ctrl_clr_stat   = 4;
    localparam int ctrl_connected  = 5;
    // instruction fields
    localparam int ind_bit    = 29;
    localparam int opc_hi     = 28;
    localparam int opc_lo     = 27;
    localparam int phase_hi   = 26;
    localparam int phase_lo   = 24;
    localparam int illop_en_bit = 0;
    // phase encodings
    localparam logic [2:0] ph_cmd     = 3'h2;
    localparam logic [2:0] ph_msg_out = 3'h6;
    localparam logic [2:0] ph_msg_in  = 3'h7;
    // command block lengths
    localparam logic [23:0] cdb_len6  = 24'h000006;
    localparam logic [23:0] cdb_len10 = 24'h00000a;
    localparam logic [23:0] cdb_len12 = 24'h00000c;
    localparam logic [31:0] reset_word = 32'h0000_0000;

    // memory master request
    typedef struct packed {
        logic        cyc;
        logic        we;
        logic [31:0] adr;
        logic [31:0] dat;
    } mem_req_s;

    // scsi lines driven by the device
    typedef struct packed {
        logic       ack;
        logic       atn;
        logic       req;
        logic [2:0] phase;
        logic [7:0] data;
        logic       phase_oe;
    } scsi_out_s;
endpackage

//--- sim/far_side_model.sv
// Purpose: memory and scsi peer facing block_move_exec
// Assumes: behavioural, one byte per scsi handshake
// Notes: released lines toggle rather than hold
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
    input  wire logic                 sys_clk,
    input  wire bmove_pkg::mem_req_s  mem_req,
    input  wire logic [1:0]           lat,
    input  wire logic                 tgt,
    input  wire logic                 go,
    input  wire logic [2:0]           ph,
    input  wire logic [7:0]           fb,
    input  wire logic [7:0]           n,
    input  wire bmove_pkg::scsi_out_s scsi_out,
    output logic                      mem_ack,
    output logic [31:0]               mem_rdata,
    output logic                      scsi_req_in,
    output logic                      scsi_ack_in,
    output logic [2:0]                scsi_phase_in,
    output logic [7:0]                scsi_data_in
);
    logic [31:0] mem [0:255];
    logic [1:0]  wt_q  = 2'h0;
    logic [1:0]  st_q  = 2'h0;
    logic [7:0]  pat_q = 8'h0;
    logic [7:0]  cnt_q = 8'h0;
    int          n_acc = 0;
    initial {mem_ack, mem_rdata, scsi_req_in, scsi_ack_in, scsi_phase_in, scsi_data_in} = '0;
    // memory answers after lat cycles, data bus toggles when idle
    always @(posedge sys_clk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req.cyc && !mem_ack) begin
            wt_q <= wt_q + 2'h1;
            if (wt_q >= lat) begin
                {wt_q, mem_ack} <= {2'h0, 1'b1};
                n_acc <= n_acc + 1;
                if (mem_req.we) mem[mem_req.adr[7:0]] <= mem_req.dat;
                else mem_rdata <= mem[mem_req.adr[7:0]];
            end
        end
    end
    // peer: initiator answering req, or target running req/ack
    always @(posedge sys_clk) begin
        if (go) begin
            {pat_q, cnt_q, st_q, scsi_req_in} <= {fb, n, 2'h0, 1'b0};
        end else if (tgt) begin
            if (scsi_out.req && !scsi_ack_in) begin
                {scsi_ack_in, scsi_data_in, pat_q} <= {1'b1, pat_q, pat_q + 8'h1};
            end else if (!scsi_out.req) begin
                {scsi_ack_in, scsi_data_in} <= {1'b0, ~scsi_data_in};
            end
        end else begin
            case (st_q)
                2'h0: if (cnt_q != 8'h0) {scsi_req_in, scsi_phase_in, scsi_data_in, st_q} <= {1'b1, ph, pat_q, 2'h1};
                2'h1: if (scsi_out.ack) begin
                    {scsi_req_in, scsi_data_in, st_q} <= {1'b0, ~scsi_data_in, 2'h2};
                    {pat_q, cnt_q} <= {pat_q + 8'h1, cnt_q - 8'h1};
                end
                default: if (!scsi_out.ack) st_q <= 2'h0;
            endcase
        end
    end
endmodule // far_side_model
`default_nettype wire

//--- sim/testbench.sv
// Purpose: self-checking bench for block_move_exec
// Assumes: far_side_model stands in for memory and scsi peer
// Notes: register reads checked by a monitor against queued notes
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed { logic [31:0] e; logic [31:0] m; } note_s;
    logic                sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic                scsi_atn_in = 1'b0, scsi_parity_err = 1'b0, go = 1'b0, tgt = 1'b0, ack_prev = 1'b0;
    logic [7:0]          wb_adr_i = 8'h0, fb = 8'h0, n = 8'h0, b;
    logic [3:0]          wb_sel_i = 4'hf;
    logic [31:0]         wb_dat_i = 32'h0, wb_dat_o, mem_rdata, q;
    logic [2:0]          ph = 3'h0, exp_ph = 3'h0, scsi_phase_in;
    logic [1:0]          lat = 2'h0;
    logic                wb_ack_o, mem_ack, irq, scsi_req_in, scsi_ack_in;
    logic [7:0]          scsi_data_in;
    bmove_pkg::mem_req_s mem_req;
    bmove_pkg::scsi_out_s scsi_out;
    int                  n_fail = 0, comparisons = 0, seed = 18941;
    note_s               nt;
    note_s               notes[$];
    logic [8:0]          seen[$];
    localparam int grp_t [6] = '{0, 1, 2, 5, 3, 3};
    localparam int cnt_t [6] = '{3, 3, 3, 3, 4, 0};
    localparam int len_t [6] = '{6, 10, 10, 12, 4, 0};

    block_move_exec block_move_exec_inst (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req, .mem_ack, .mem_rdata, .scsi_req_in, .scsi_ack_in, .scsi_atn_in,
        .scsi_parity_err, .scsi_phase_in, .scsi_data_in, .scsi_out, .irq);
    far_side_model far_side_model_inst (.sys_clk, .mem_req, .lat, .tgt, .go, .ph, .fb, .n, .scsi_out, .mem_ack,
        .mem_rdata, .scsi_req_in, .scsi_ack_in, .scsi_phase_in, .scsi_data_in);

    // clock
    always #25 sys_clk = ~sys_clk;

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // classic wishbone cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        lat <= 2'($random(seed));
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] r);
        notes.push_back('{e, m});
        wb(1'b0, a, 32'h0, r);
    endtask

    // compare each read whose note has a nonzero mask against the oldest note
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.m != 32'h0) cmp(wb_dat_o & nt.m, nt.e & nt.m);
        end
    end

    // log ack rises with atn and data, check phase driven as target
    always @(posedge sys_clk) begin
        ack_prev <= scsi_out.ack;
        if (scsi_out.ack && !ack_prev) seen.push_back({scsi_out.atn, scsi_out.data});
        if (tgt && scsi_out.req) cmp(32'({scsi_out.phase_oe, scsi_out.phase}), 32'({1'b1, exp_ph}));
    end

    // one program: move at 0, stop word at 8, then poll for the end
    task automatic run(input logic [31:0] w0, input logic [31:0] w2, input logic [5:0] ctl, input logic [2:0] pph,
                       input logic [7:0] pb, input int cnt, input logic [31:0] st, input logic [31:0] na,
                       input int acc, input logic ien, input logic hold);
        logic [31:0] r;
        int          a0;
        for (int k = 128; k < 192; k++) far_side_model_inst.mem[k] = 32'h0;
        far_side_model_inst.mem[0] = w0;
        far_side_model_inst.mem[4] = w0[29] ? 32'h40 : 32'h80;
        far_side_model_inst.mem[8] = w2;
        far_side_model_inst.mem[12] = na;
        {tgt, ph, n, go, fb, exp_ph} <= {ctl[1], pph, 8'(cnt), 1'b1, pb, w0[26:24]};
        @(posedge sys_clk);
        go <= 1'b0;
        wr(bmove_pkg::off_ctrl, 32'(ctl) | 32'h10);
        cmp(32'(irq), 32'h0);
        wr(bmove_pkg::off_irq_en, 32'(ien));
        wr(bmove_pkg::off_addr, 32'h0);
        a0 = far_side_model_inst.n_acc;
        wr(bmove_pkg::off_ctrl, (32'(ctl) & ~(32'(hold) << 5)) | 32'h1);
        if (hold) begin
            repeat (20) @(posedge sys_clk);
            cmp(32'({scsi_out.req, scsi_out.ack}), 32'h0);
            rd(bmove_pkg::off_status, 32'h0, 32'he, r);
            wr(bmove_pkg::off_ctrl, 32'(ctl));
        end
        r = 32'h0;
        for (int k = 0; k < 400 && r[3:1] == 3'h0; k++) rd(bmove_pkg::off_status, 32'h0, 32'h0, r);
        cmp(r & 32'he, st);
        cmp(32'(irq), 32'(st != 32'h8 || ien));
        if (acc >= 0) begin
            cmp(32'(far_side_model_inst.n_acc - a0), 32'(acc));
            rd(bmove_pkg::off_addr, na, 32'hffffffff, r);
            rd(bmove_pkg::off_cmd, w2, 32'hffffffff, r);
        end
        if (!ctl[1]) rd(bmove_pkg::off_phase, 32'(pph), 32'h7, r);
    endtask

    // watchdog
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(bmove_pkg::off_status, 32'h0, 32'hffffffff, q);
        wr(8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h0, 32'hffffffff, q);
        wr(bmove_pkg::off_irq_en, 32'h1);
        rd(bmove_pkg::off_irq_en, 32'h1, 32'h1, q);
        b = 8'($random(seed));
        run({5'h01, 3'h1, 24'd3}, {5'h02, 27'h0}, 6'h20, 3'h1, b, 3, 32'h8, 32'h83, 7, 1'b1, 1'b1);
        for (int k = 0; k < 3; k++) cmp(far_side_model_inst.mem[128 + k] & 32'hff, 32'(b + 8'(k)));
        far_side_model_inst.mem[64] = 32'hc0;
        far_side_model_inst.mem[192] = 32'($random(seed));
        far_side_model_inst.mem[193] = 32'($random(seed));
        seen.delete();
        run({5'h05, 3'h6, 24'd2}, {5'h03, 27'h0}, 6'h20, 3'h6, 8'h0, 2, 32'h8, 32'hc2, 7, 1'b0, 1'b0);
        cmp(32'(seen.size()), 32'h2);
        for (int k = 0; k < seen.size() && k < 2; k++)
            cmp(32'(seen[k]), 32'({k == 0, far_side_model_inst.mem[192 + k][7:0]}));
        run({5'h01, 3'h1, 24'd1}, {5'h02, 27'h0}, 6'h20, 3'h3, 8'h0, 1, 32'h4, 32'h0, -1, 1'b0, 1'b0);
        run({5'h01, 3'h7, 24'd2}, {5'h02, 27'h0}, 6'h20, 3'h7, 8'($random(seed)), 2, 32'h8, 32'h82, 6, 1'b1,
            1'b0);
        cmp(32'(scsi_out.ack), 32'h1);
        wr(bmove_pkg::off_ctrl, 32'h28);
        for (int k = 0; k < 10 && scsi_out.ack; k++) @(posedge sys_clk);
        cmp(32'(scsi_out.ack), 32'h0);
        for (int k = 0; k < 6; k++) begin
            b = {3'(grp_t[k]), 5'($random(seed))};
            run({5'h00, 3'h2, 24'(cnt_t[k])}, {5'(1 + k % 3), 27'h0}, 6'h22, 3'h2, b, 0, 32'h8,
                32'h80 + 32'(len_t[k]), k == 5 ? -1 : 4 + len_t[k], 1'b1, k == 0);
            for (int j = 0; j < len_t[k]; j++) cmp(far_side_model_inst.mem[128 + j] & 32'hff, 32'(b + 8'(j)));
        end
        for (int k = 0; k < 2; k++) begin
            {scsi_atn_in, scsi_parity_err} <= (k == 1) ? 2'b01 : 2'b10;
            run({5'h00, 3'h1, 24'd4}, {5'h01, 27'h0}, (k == 1) ? 6'h26 : 6'h22, 3'h1, 8'h0, 0,
                (k == 1) ? 32'h8 : 32'h2, 32'h84, (k == 1) ? 8 : -1, 1'b0, 1'b0);
        end
        {scsi_atn_in, scsi_parity_err} <= 2'b00;
        final_report();
    end
endmodule // testbench
`default_nettype wire
